// File: rtl/isr_status_map.vh
// Register indices, field positions and reset values of the status reporting block.
`ifndef ISR_STATUS_MAP_VH
`define ISR_STATUS_MAP_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define ISR_IDX_OPER_COND 4'h0
`define ISR_IDX_OPER_EVENT 4'h1
`define ISR_IDX_OPER_ENABLE 4'h2
`define ISR_IDX_QUES_COND 4'h3
`define ISR_IDX_QUES_EVENT 4'h4
`define ISR_IDX_QUES_ENABLE 4'h5
`define ISR_IDX_STD_COND 4'h6
`define ISR_IDX_STD_EVENT 4'h7
`define ISR_IDX_STD_ENABLE 4'h8
`define ISR_IDX_SRQ_STATUS 4'h9
`define ISR_IDX_SRQ_EVENT 4'ha
`define ISR_IDX_SRQ_ENABLE 4'hb

// ----------------------------------------------------------------
// Operation condition fields
// ----------------------------------------------------------------
`define ISR_OPER_CV_BIT 8
`define ISR_OPER_CC_BIT 10

// ----------------------------------------------------------------
// Questionable condition fields
// ----------------------------------------------------------------
`define ISR_QUES_VMODE_BIT 0
`define ISR_QUES_CMODE_BIT 1
`define ISR_QUES_THERM_BIT 3
`define ISR_QUES_VERR_BIT 12
`define ISR_QUES_CERR_BIT 13
`define ISR_QUES_NOEDGE_MASK 16'h0002

// ----------------------------------------------------------------
// Service request byte fields
// ----------------------------------------------------------------
`define ISR_SRQ_ERR_BIT 3
`define ISR_SRQ_MAV_BIT 4
`define ISR_SRQ_STD_BIT 5
`define ISR_SRQ_RQS_BIT 6
`define ISR_SRQ_OPER_BIT 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ISR_RST_16 16'h0000
`define ISR_RST_8 8'h00
`define ISR_RST_PIN 5'h00

`endif

// File: rtl/isr_status_reporting.v
// Status reporting block: condition, event and enable registers with service request.
`timescale 1ns/1ps
`include "isr_status_map.vh"

// ----------------------------------------------------------------
// Event and enable register pair
// ----------------------------------------------------------------
module isr_event_reg #(
    parameter W = 16,
    parameter [W-1:0] NOEDGE = {W{1'b0}}
) (
    input wire clk,
    input wire rstN,
    input wire [W-1:0] cond,
    input wire enableWr,
    input wire [W-1:0] enableData,
    input wire eventRd,
    output reg [W-1:0] eventBits,
    output reg [W-1:0] enableBits,
    output wire summary
);
    reg [W-1:0] condPrev;
    wire [W-1:0] rise;

    assign rise = cond & ~condPrev & ~NOEDGE;
    assign summary = |eventBits;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            condPrev <= {W{1'b0}};
            eventBits <= {W{1'b0}};
            enableBits <= {W{1'b0}};
        end else begin
            condPrev <= cond;
            eventBits <= (eventRd ? {W{1'b0}} : eventBits) | (rise & enableBits);
            if (enableWr) begin
                enableBits <= enableData;
            end
        end
    end
endmodule // isr_event_reg

module isr_status_reporting (
    input wire clk,
    input wire rst_b,
    input wire voltModePin,
    input wire currModePin,
    input wire thermalPin,
    input wire voltFaultPin,
    input wire currFaultPin,
    input wire cmdDone,
    input wire cmdError,
    input wire errQueueNotEmpty,
    input wire outputAvail,
    input wire [7:0] stdCond,
    input wire regRd,
    input wire regWr,
    input wire [3:0] regSel,
    input wire [15:0] regWrData,
    output reg [15:0] regRdData,
    output reg regRdValid,
    output reg [7:0] statusByte,
    output wire srqAssert
);
    reg rstSync1;
    reg rstSync2;
    wire rstN;
    reg [4:0] pinSync1;
    reg [4:0] pinSync2;
    reg lastCmdErr;
    reg [15:0] operCond;
    reg [15:0] quesCond;
    reg [7:0] next_statusByte;
    reg [15:0] next_regRdData;
    reg [7:0] statusBase;
    wire [15:0] operEvent;
    wire [15:0] operEnable;
    wire [15:0] quesEvent;
    wire [15:0] quesEnable;
    wire [7:0] stdEvent;
    wire [7:0] stdEnable;
    wire [7:0] srqEvent;
    wire [7:0] srqEnable;
    wire operSum;
    wire quesSum;
    wire stdSum;
    wire rdOperEv;
    wire rdQuesEv;
    wire rdStdEv;
    wire rdSrqEv;
    wire wrOperEn;
    wire wrQuesEn;
    wire wrStdEn;
    wire wrSrqEn;

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    assign rstN = rstSync2;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinSync1 <= `ISR_RST_PIN;
            pinSync2 <= `ISR_RST_PIN;
        end else begin
            pinSync1 <= {currFaultPin, voltFaultPin, thermalPin, currModePin, voltModePin};
            pinSync2 <= pinSync1;
        end
    end

    // ----------------------------------------------------------------
    // Condition registers
    // ----------------------------------------------------------------
    always @* begin
        operCond = `ISR_RST_16;
        quesCond = `ISR_RST_16;
        operCond[`ISR_OPER_CV_BIT] = pinSync2[0];
        operCond[`ISR_OPER_CC_BIT] = pinSync2[1];
        quesCond[`ISR_QUES_VMODE_BIT] = pinSync2[0];
        quesCond[`ISR_QUES_CMODE_BIT] = pinSync2[1];
        quesCond[`ISR_QUES_THERM_BIT] = pinSync2[2];
        quesCond[`ISR_QUES_VERR_BIT] = pinSync2[3];
        quesCond[`ISR_QUES_CERR_BIT] = pinSync2[4];
    end

    // ----------------------------------------------------------------
    // Event and enable registers
    // ----------------------------------------------------------------
    assign rdOperEv = regRd && (regSel == `ISR_IDX_OPER_EVENT);
    assign rdQuesEv = regRd && (regSel == `ISR_IDX_QUES_EVENT);
    assign rdStdEv = regRd && (regSel == `ISR_IDX_STD_EVENT);
    assign rdSrqEv = regRd && (regSel == `ISR_IDX_SRQ_EVENT);

    assign wrOperEn = regWr && (regSel == `ISR_IDX_OPER_ENABLE);
    assign wrQuesEn = regWr && (regSel == `ISR_IDX_QUES_ENABLE);
    assign wrStdEn = regWr && (regSel == `ISR_IDX_STD_ENABLE);
    assign wrSrqEn = regWr && (regSel == `ISR_IDX_SRQ_ENABLE);

    isr_event_reg #(.W(16)) operRegs (
        .clk(clk),
        .rstN(rstN),
        .cond(operCond),
        .enableWr(wrOperEn),
        .enableData(regWrData),
        .eventRd(rdOperEv),
        .eventBits(operEvent),
        .enableBits(operEnable),
        .summary(operSum)
    );

    // current mode bit has no edge
    isr_event_reg #(.W(16), .NOEDGE(`ISR_QUES_NOEDGE_MASK)) quesRegs (
        .clk(clk),
        .rstN(rstN),
        .cond(quesCond),
        .enableWr(wrQuesEn),
        .enableData(regWrData),
        .eventRd(rdQuesEv),
        .eventBits(quesEvent),
        .enableBits(quesEnable),
        .summary(quesSum)
    );

    isr_event_reg #(.W(8)) stdRegs (
        .clk(clk),
        .rstN(rstN),
        .cond(stdCond),
        .enableWr(wrStdEn),
        .enableData(regWrData[7:0]),
        .eventRd(rdStdEv),
        .eventBits(stdEvent),
        .enableBits(stdEnable),
        .summary(stdSum)
    );

    isr_event_reg #(.W(8)) srqRegs (
        .clk(clk),
        .rstN(rstN),
        .cond(statusByte),
        .enableWr(wrSrqEn),
        .enableData(regWrData[7:0]),
        .eventRd(rdSrqEv),
        .eventBits(srqEvent),
        .enableBits(srqEnable),
        .summary()
    );

    // ----------------------------------------------------------------
    // Command error flag and service request byte
    // ----------------------------------------------------------------
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            lastCmdErr <= 1'b0;
        end else if (cmdDone) begin
            lastCmdErr <= cmdError;
        end
    end

    always @* begin
        statusBase = `ISR_RST_8;
        // error bit clear after good command unless questionable summary or error queue flag is set
        statusBase[`ISR_SRQ_ERR_BIT] = quesSum | errQueueNotEmpty | lastCmdErr;
        statusBase[`ISR_SRQ_MAV_BIT] = outputAvail;
        statusBase[`ISR_SRQ_STD_BIT] = stdSum;
        statusBase[`ISR_SRQ_OPER_BIT] = operSum;
    end

    always @* begin
        next_statusByte = statusBase;
        next_statusByte[`ISR_SRQ_RQS_BIT] = |(statusBase & srqEnable);
    end

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            statusByte <= `ISR_RST_8;
        end else begin
            statusByte <= next_statusByte;
        end
    end

    assign srqAssert = statusByte[`ISR_SRQ_RQS_BIT];

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always @* begin
        next_regRdData = `ISR_RST_16;
        case (regSel)
            `ISR_IDX_OPER_COND: next_regRdData = operCond;
            `ISR_IDX_OPER_EVENT: next_regRdData = operEvent;
            `ISR_IDX_OPER_ENABLE: next_regRdData = operEnable;
            `ISR_IDX_QUES_COND: next_regRdData = quesCond;
            `ISR_IDX_QUES_EVENT: next_regRdData = quesEvent;
            `ISR_IDX_QUES_ENABLE: next_regRdData = quesEnable;
            `ISR_IDX_STD_COND: next_regRdData = {8'h00, stdCond};
            `ISR_IDX_STD_EVENT: next_regRdData = {8'h00, stdEvent};
            `ISR_IDX_STD_ENABLE: next_regRdData = {8'h00, stdEnable};
            `ISR_IDX_SRQ_STATUS: next_regRdData = {8'h00, statusByte};
            `ISR_IDX_SRQ_EVENT: next_regRdData = {8'h00, srqEvent};
            `ISR_IDX_SRQ_ENABLE: next_regRdData = {8'h00, srqEnable};
            default: next_regRdData = `ISR_RST_16;
        endcase
    end

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regRdData <= `ISR_RST_16;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRd;
            if (regRd) begin
                regRdData <= next_regRdData;
            end
        end
    end
endmodule // isr_status_reporting

// File: sim/isr_status_reporting_assertions.sv
// Port checker of the status reporting block.
`timescale 1ns/1ps
module isr_status_reporting_assertions (
    input wire clk,
    input wire rst_b,
    input wire cmdDone,
    input wire cmdError,
    input wire errQueueNotEmpty,
    input wire outputAvail,
    input wire regRd,
    input wire [3:0] regSel,
    input wire [15:0] regRdData,
    input wire regRdValid,
    input wire [7:0] statusByte,
    input wire srqAssert
);
    reg [2:0] upPipe;
    wire live = upPipe[2];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            upPipe <= 3'h0;
        end else begin
            upPipe <= {upPipe[1:0], 1'b1};
        end
    end
    AST_RD_ANSWER: assert property (live && regRd |=> regRdValid)
        else $error("read strobe got no valid pulse");
    AST_RD_CAUSE: assert property (regRdValid |-> $past(regRd))
        else $error("valid pulse without read strobe");
    AST_SRQ_LINE: assert property (srqAssert == statusByte[6])
        else $error("service request line differs from status bit 6");
    AST_DATA_AVAIL: assert property (live |-> statusByte[4] == $past(outputAvail))
        else $error("status bit 4 does not follow output data flag");
    AST_QUEUE_FLAG: assert property (live && $past(errQueueNotEmpty) |-> statusByte[3])
        else $error("status bit 3 low with queue not empty");
    AST_CMD_ERROR: assert property (live && cmdDone && cmdError |=> ##1 statusByte[3])
        else $error("failed command left status bit 3 low");
    AST_OPER_ZERO: assert property (regRdValid && $past(regSel) == 4'h0 |->
        (regRdData & 16'hfafe) == 16'h0000)
        else $error("unused operation bit read as one");
    AST_QUES_ZERO: assert property (regRdValid && $past(regSel) == 4'h3 |->
        (regRdData & 16'hcff4) == 16'h0000)
        else $error("unused questionable bit read as one");
    AST_QUES_NOEDGE: assert property (regRdValid && $past(regSel) == 4'h4 |->
        !regRdData[1])
        else $error("current mode edge reached event register");
    AST_NARROW: assert property (regRdValid && $past(regSel) inside {[4'h6:4'hb]} |->
        regRdData[15:8] == 8'h00)
        else $error("eight bit register shows upper byte");
    COV_READ: cover property (regRdValid);
    COV_SRQ: cover property (srqAssert);
    COV_CMD_ERR: cover property (cmdDone && cmdError);
endmodule // isr_status_reporting_assertions

bind isr_status_reporting isr_status_reporting_assertions chk (.clk(clk), .rst_b(rst_b),
    .cmdDone(cmdDone), .cmdError(cmdError), .errQueueNotEmpty(errQueueNotEmpty),
    .outputAvail(outputAvail), .regRd(regRd), .regSel(regSel), .regRdData(regRdData),
    .regRdValid(regRdValid), .statusByte(statusByte), .srqAssert(srqAssert));

// File: sim/isr_host_model.sv
// Host controller model that strobes register reads and writes.
`timescale 1ns/1ps
module isr_host_model (
    input wire clk,
    input wire [15:0] regRdData,
    input wire regRdValid,
    output logic regRd,
    output logic regWr,
    output logic [3:0] regSel,
    output logic [15:0] regWrData
);
    initial begin
        regRd = 1'b0;
        regWr = 1'b0;
        regSel = 4'hf;
        regWrData = 16'h0000;
    end
    task automatic wr(input logic [3:0] sel, input logic [15:0] d);
        @(negedge clk);
        regWr = 1'b1;
        regSel = sel;
        regWrData = d;
        @(negedge clk);
        regWr = 1'b0;
        regSel = ~sel;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [3:0] sel, output logic [15:0] d, output logic v);
        @(negedge clk);
        regRd = 1'b1;
        regSel = sel;
        @(negedge clk);
        regRd = 1'b0;
        regSel = ~sel;
        v = regRdValid;
        d = regRdData;
    endtask
endmodule // isr_host_model

// File: sim/isr_status_reporting_tb.sv
// Testbench of the status reporting block.
`timescale 1ns/1ps
module isr_status_reporting_tb;
    logic clk, rst_b, vm, cm, th, vf, cf, cmdDone, cmdError, errQ, avail;
    logic regRd, regWr, regRdValid, srqAssert, rdV;
    logic [3:0] regSel;
    logic [15:0] regWrData, regRdData, rdD;
    logic [7:0] statusByte, stdC;
    int mismatches = 0;
    int n_checks = 0;
    isr_status_reporting uut (.clk(clk), .rst_b(rst_b), .voltModePin(vm),
        .currModePin(cm), .thermalPin(th), .voltFaultPin(vf), .currFaultPin(cf),
        .cmdDone(cmdDone), .cmdError(cmdError), .errQueueNotEmpty(errQ),
        .outputAvail(avail), .stdCond(stdC), .regRd(regRd), .regWr(regWr),
        .regSel(regSel), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .statusByte(statusByte), .srqAssert(srqAssert));
    isr_host_model host (.clk(clk), .regRdData(regRdData), .regRdValid(regRdValid),
        .regRd(regRd), .regWr(regWr), .regSel(regSel), .regWrData(regWrData));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [3:0] sel, input logic [15:0] e, input string nm);
        host.rd(sel, rdD, rdV);
        chkb("readValid", 1'b1, rdV);
        chk(nm, e, rdD);
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_reset;
        for (int i = 1; i < 16; i++) rchk(4'(i), 16'h0000, "afterReset");
    endtask
    task automatic t_oper;
        vm = 1'b1;
        wt(6);
        rchk(4'h0, 16'h0100, "operCv");
        rchk(4'h3, 16'h0001, "quesVm");
        vm = 1'b0;
        cm = 1'b1;
        wt(6);
        rchk(4'h0, 16'h0400, "operCc");
        rchk(4'h3, 16'h0002, "quesCm");
    endtask
    task automatic t_ques;
        cm = 1'b0;
        wt(6);
        host.wr(4'h5, 16'hfffe);
        {cm, vm, th, vf, cf} = 5'h1f;
        wt(6);
        rchk(4'h3, 16'h300b, "quesCond");
        chkb("quesSummary", 1'b1, statusByte[3]);
        rchk(4'h4, 16'h3008, "quesEvent");
        wt(3);
        chkb("quesSummaryClr", 1'b0, statusByte[3]);
        rchk(4'h4, 16'h0000, "quesEventClr");
    endtask
    task automatic t_srq;
        avail = 1'b1;
        host.wr(4'hb, 16'h0010);
        wt(3);
        chkb("dataAvail", 1'b1, statusByte[4]);
        chkb("rqsSet", 1'b1, statusByte[6]);
        chkb("srqOn", 1'b1, srqAssert);
        host.wr(4'hb, 16'h0040);
        wt(3);
        chkb("rqsSelf", 1'b0, statusByte[6]);
        avail = 1'b0;
        errQ = 1'b1;
        host.wr(4'hb, 16'h0008);
        wt(3);
        chkb("queueFlag", 1'b1, statusByte[3]);
        chkb("srqQueue", 1'b1, srqAssert);
        errQ = 1'b0;
        host.wr(4'hb, 16'h0000);
        wt(3);
        chkb("srqOff", 1'b0, srqAssert);
    endtask
    task automatic t_cmd;
        {cmdDone, cmdError} = 2'h3;
        wt(1);
        {cmdDone, cmdError} = 2'h0;
        wt(3);
        chkb("cmdBad", 1'b1, statusByte[3]);
        cmdDone = 1'b1;
        wt(1);
        cmdDone = 1'b0;
        wt(3);
        chkb("cmdGood", 1'b0, statusByte[3]);
    endtask
    task automatic t_std;
        vm = 1'b0;
        cm = 1'b0;
        host.wr(4'hb, 16'h00a0);
        host.wr(4'h8, 16'h0001);
        host.wr(4'h2, 16'h0100);
        stdC = 8'h01;
        vm = 1'b1;
        wt(6);
        chkb("stdSummary", 1'b1, statusByte[5]);
        chkb("operSummary", 1'b1, statusByte[7]);
        chkb("srqStdOper", 1'b1, srqAssert);
        rchk(4'h7, 16'h0001, "stdEvent");
        rchk(4'h1, 16'h0100, "operEvent");
        rchk(4'ha, 16'h00a0, "srqEvent");
        rchk(4'h7, 16'h0000, "stdEventClr");
        rchk(4'h1, 16'h0000, "operEventClr");
        rchk(4'ha, 16'h0000, "srqEventClr");
        wt(3);
        chkb("srqClr", 1'b0, srqAssert);
    endtask
    task automatic t_rerst;
        rst_b = 1'b0;
        wt(2);
        rst_b = 1'b1;
        wt(4);
        for (int i = 1; i < 12; i++) begin
            if (i % 3 != 0) begin
                rchk(4'(i), 16'h0000, "afterRerst");
            end
        end
        chkb("statusRerst", 1'b0, statusByte[6]);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100us;
        mismatches++;
        tally_and_finish;
    end
    initial begin
        rst_b = 1'b0;
        {vm, cm, th, vf, cf, cmdDone, cmdError, errQ, avail} = 9'h000;
        stdC = 8'h00;
        wt(8);
        rst_b = 1'b1;
        wt(4);
        t_reset;
        t_oper;
        t_ques;
        t_srq;
        t_cmd;
        t_std;
        t_rerst;
        tally_and_finish;
    end
endmodule // isr_status_reporting_tb
